// *** hdl/led_port_cfg.svh ***
// Constants for the LED driver serial write port.
`ifndef LED_PORT_CFG_SVH
`define LED_PORT_CFG_SVH
`define CLK_FREQ_KHZ      100000
`define LINK_MAX_KHZ      5000
`define STD_HS_MAX_KHZ    3400
`define LINK_SAMPLES      (`CLK_FREQ_KHZ / `LINK_MAX_KHZ)
`define STD_SAMPLES       (`CLK_FREQ_KHZ / `STD_HS_MAX_KHZ)
`define SEL_LOW           2'h0
`define SEL_MID           2'h1
`define SEL_HIGH          2'h3
`define DEV_ADDR_MSB      1'h1
`define DEV_ADDR_LSB      1'h0
`define ADDR_GRP_HI       5:3
`define ADDR_GRP_BAR_ALL  3'h7
`define ADDR_GRP_BAR_STD  3'h6
`define START_ONES        4'h9
`define BIT_LAST_SHORT    4'h7
`define BIT_LAST_LONG     4'h8
`define REG_FIRST         8'h00
`define REG_LAST          8'h1D
`define REG_RESET_VAL     8'h00
`define REG_AW            5
`define REG_DEPTH         32
`define FIFO_DEPTH        8
`endif

// *** hdl/led_port_pkg.sv ***
// Types shared by the LED driver serial write port.
package led_port_pkg;
   typedef enum logic [1:0] {
      MODE_3W  = 2'b00,
      MODE_STD = 2'b01,
      MODE_2W  = 2'b11
   } link_mode_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_DEV  = 3'b001,
      PH_REG  = 3'b010,
      PH_DATA = 3'b011,
      PH_SKIP = 3'b100
   } phase_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_t;
endpackage : led_port_pkg

// *** hdl/sync_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             push;
   logic             pop;
   logic             full;
   logic             empty;

   assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign empty = (wr_ptr_q == rd_ptr_q);
   assign push  = in_valid_in && !full;
   assign pop   = out_ready_in && !empty;
   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end
endmodule : sync_fifo

// *** hdl/cfg_reg_mem.sv ***
// Configuration register storage with one write port and a registered read port.
`timescale 1ns/1ps
module cfg_reg_mem #(
   parameter int AW    = 5,
   parameter int DEPTH = 32
) (
   input  wire logic          clk_in,
   input  wire logic          rstn_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic [7:0]         rdata_out
);
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= mem_q[raddr_in];
      end
   end
endmodule : cfg_reg_mem

// *** hdl/led_driver_serial_write_port.sv ***
// Serial write port of the LED driver: three link modes into configuration registers.
//
// Overview of operation
// RULE_01: Select pin low/high/mid picks 3-wire/2-wire/standard.
// RULE_02: Link modes accept clocks up to 5 MHz.
// RULE_03: Standard bus accepts Hs-mode up to 3.4 MHz.
// RULE_04: Message is device, register, then data bytes.
// RULE_05: Register address increments, wraps to 00h.
// RULE_06: Device address is 1, select pins, 0.
// RULE_07: 56 addresses on links, 48 on standard bus.
// RULE_08: 3-wire frame spans enable rise to fall.
// RULE_09: 3-wire samples data on clock rise.
// RULE_10: Short 3-wire frames latch no data.
// RULE_11: Longer 3-wire frames write further bytes, incrementing.
// RULE_12: 2-wire start is nine ones then zero.
// RULE_13: 2-wire start mid-transfer restarts reception.
// RULE_14: 2-wire bytes latch only on zero separator.
// RULE_15: 2-wire further data bytes increment address.
// RULE_16: 2-wire bad separator discards until next start.
// RULE_17: Host sends at least 37 bits in 2-wire.
// RULE_18: Too few 2-wire clocks take no data.
// RULE_19: Standard bus accepts ordinary write transfers.
// RULE_20: Read transfers are not supported.
// RULE_21: Standard start and stop while clock high.
// RULE_22: Host keeps data stable while clock high.
// RULE_23: Power-on reset clears all configuration registers.
// RULE_24: Foreign device address ignores rest of message.
// RULE_25: Standard bus acknowledges each accepted byte.
`timescale 1ns/1ps
`include "led_port_cfg.svh"
module led_driver_serial_write_port (
   input  wire logic                     clk_in,
   input  wire logic                     rstn_in,
   input  wire logic                     serial_clock_pin_in,
   input  wire logic                     serial_data_pin_in,
   input  wire logic                     frame_enable_pin_in,
   input  wire logic [1:0]               bus_type_select_pin_in,
   input  wire logic [5:0]               address_select_pins_in,
   input  wire logic [`REG_AW-1:0]       cfg_rd_addr_in,
   output logic [7:0]                    cfg_rd_data_out,
   output logic                          serial_data_pin_out,
   output logic                          serial_data_pin_oe_n_out,
   output led_port_pkg::link_mode_t      link_mode_out,
   output logic                          frame_active_out,
   output logic                          write_drop_out,
   output logic                          clear_busy_out
);
   import led_port_pkg::*;

   // Synchroniser stages for the link and select pins, and edge history for the link pins.
   logic [2:0]       pin_s1_q;
   logic [2:0]       pin_s2_q;
   logic [2:0]       pin_h_q;
   logic [7:0]       cfg_s1_q;
   logic [7:0]       cfg_s2_q;

   logic             sclk;
   logic             sdat;
   logic             frame_enable_pin;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             sdat_rise;
   logic             sdat_fall;
   logic             frame_enable_pin_rise;

   link_mode_t       mode_q;
   link_mode_t       mode_d;
   phase_t           phase_q;
   logic [3:0]       bit_cnt_q;
   logic [7:0]       shift_q;
   logic [3:0]       ones_q;
   logic [7:0]       reg_addr_q;

   logic             bit_evt;
   logic [3:0]       bit_last;
   logic             at_last;
   logic             byte_evt;
   logic [7:0]       byte_val;
   logic             sep_bad;
   logic             msg_start;
   logic             msg_end;
   logic [7:0]       dev_addr;
   logic             addr_ok;
   logic             dev_match;
   logic             ack_now;

   logic             ack_pend_q;
   logic             ack_drive_q;
   logic             drop_q;

   wr_req_t          push_req;
   logic             push_valid;
   logic             push_ready;
   wr_req_t          pop_req;
   logic             pop_valid;
   logic             pop_ready;

   logic             clr_busy_q;
   logic [`REG_AW-1:0] clr_idx_q;
   logic             mem_we;
   logic [`REG_AW-1:0] mem_waddr;
   logic [7:0]       mem_wdata;

   // Every pin passes two flops before use; sampling at 100 MHz covers both
   // the 5 MHz link clock and the 3.4 MHz high-speed clock with margin.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_h_q  <= 3'h0;
      end else begin
         pin_s1_q <= {frame_enable_pin_in, serial_data_pin_in, serial_clock_pin_in}; // RULE_02 RULE_03
         pin_s2_q <= pin_s1_q;
         pin_h_q  <= pin_s2_q;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg_s1_q <= 8'h00;
         cfg_s2_q <= 8'h00;
      end else begin
         cfg_s1_q <= {bus_type_select_pin_in, address_select_pins_in};
         cfg_s2_q <= cfg_s1_q;
      end
   end

   assign sclk      = pin_s2_q[0];
   assign sdat      = pin_s2_q[1];
   assign frame_enable_pin      = pin_s2_q[2];
   assign sclk_rise = pin_s2_q[0] && !pin_h_q[0];
   assign sclk_fall = !pin_s2_q[0] && pin_h_q[0];
   assign sdat_rise = pin_s2_q[1] && !pin_h_q[1];
   assign sdat_fall = !pin_s2_q[1] && pin_h_q[1];
   assign frame_enable_pin_rise = pin_s2_q[2] && !pin_h_q[2];

   // Three-level select pin decode.
   always_comb begin
      case (cfg_s2_q[7:6])
         `SEL_LOW:  mode_d = MODE_3W;   // RULE_01
         `SEL_HIGH: mode_d = MODE_2W;   // RULE_01
         `SEL_MID:  mode_d = MODE_STD;  // RULE_01
         default:   mode_d = MODE_STD;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_q <= MODE_3W;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Own device address and the usable subset per mode.
   assign dev_addr = {`DEV_ADDR_MSB, cfg_s2_q[5:0], `DEV_ADDR_LSB}; // RULE_06
   always_comb begin
      addr_ok = (cfg_s2_q[`ADDR_GRP_HI] != `ADDR_GRP_BAR_ALL); // RULE_07
      if (mode_q == MODE_STD && cfg_s2_q[`ADDR_GRP_HI] == `ADDR_GRP_BAR_STD) begin
         addr_ok = 1'b0; // RULE_07
      end
   end
   // A read request carries bit 0 set and therefore never matches.
   assign dev_match = (byte_val == dev_addr) && addr_ok; // RULE_06 RULE_20

   // Bit sampling per mode.
   always_comb begin
      case (mode_q)
         MODE_3W:  bit_evt = frame_enable_pin && sclk_rise;  // RULE_08 RULE_09
         MODE_2W:  bit_evt = sclk_rise;          // RULE_12
         MODE_STD: bit_evt = sclk_rise;          // RULE_19
         default:  bit_evt = 1'b0;
      endcase
   end

   // The 3-wire link packs plain 8-bit bytes; the other modes add a ninth slot.
   assign bit_last = (mode_q == MODE_3W) ? `BIT_LAST_SHORT : `BIT_LAST_LONG;
   assign at_last  = (bit_cnt_q == bit_last);
   assign byte_val = (mode_q == MODE_2W) ? shift_q : {shift_q[6:0], sdat};

   always_comb begin
      byte_evt  = 1'b0;
      sep_bad   = 1'b0;
      msg_start = 1'b0;
      msg_end   = 1'b0;
      case (mode_q)
         MODE_3W: begin
            msg_start = frame_enable_pin_rise;                               // RULE_08
            msg_end   = !frame_enable_pin;                                   // RULE_08
            byte_evt  = bit_evt && at_last;                      // RULE_10
         end
         MODE_2W: begin
            msg_start = bit_evt && !sdat && (ones_q == `START_ONES); // RULE_12 RULE_13
            byte_evt  = bit_evt && at_last && !sdat && !msg_start;   // RULE_14 RULE_18
            sep_bad   = bit_evt && at_last && sdat;                  // RULE_16
         end
         MODE_STD: begin
            msg_start = sclk && sdat_fall;                       // RULE_21
            msg_end   = sclk && sdat_rise;                       // RULE_21
            byte_evt  = bit_evt && (bit_cnt_q == `BIT_LAST_SHORT); // RULE_19 RULE_22
         end
         default: begin
            msg_end = 1'b1;
         end
      endcase
   end

   // Run of consecutive ones for the 2-wire start pattern.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ones_q <= 4'h0;
      end else if (mode_q != MODE_2W) begin
         ones_q <= 4'h0;
      end else if (bit_evt) begin
         if (!sdat) begin
            ones_q <= 4'h0;
         end else if (ones_q != `START_ONES) begin
            ones_q <= ones_q + 4'h1; // RULE_12
         end
      end
   end

   // Shift register and bit position inside the current byte.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
      end else if (mode_q != mode_d || msg_start || msg_end) begin
         bit_cnt_q <= 4'h0; // RULE_13
      end else if (bit_evt) begin
         if (at_last) begin
            bit_cnt_q <= 4'h0;
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         if (!(mode_q != MODE_3W && at_last)) begin
            shift_q <= {shift_q[6:0], sdat};
         end
      end
   end

   // Message phase: device address, register address, then data bytes.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         phase_q <= PH_IDLE;
      end else if (mode_q != mode_d || clr_busy_q) begin
         phase_q <= PH_IDLE;
      end else if (msg_start) begin
         phase_q <= PH_DEV; // RULE_13 RULE_21
      end else if (msg_end) begin
         phase_q <= PH_IDLE; // RULE_08 RULE_21
      end else if (sep_bad && phase_q != PH_IDLE) begin
         phase_q <= PH_SKIP; // RULE_16
      end else if (byte_evt) begin
         case (phase_q)
            PH_DEV:  phase_q <= dev_match ? PH_REG : PH_SKIP; // RULE_04 RULE_24
            PH_REG:  phase_q <= PH_DATA; // RULE_04
            PH_DATA: phase_q <= PH_DATA;
            PH_SKIP: phase_q <= PH_SKIP; // RULE_24
            default: phase_q <= PH_IDLE;
         endcase
      end
   end

   // Register address pointer with wrap after the highest register.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_addr_q <= `REG_FIRST;
      end else if (byte_evt && phase_q == PH_REG) begin
         reg_addr_q <= byte_val; // RULE_04
      end else if (byte_evt && phase_q == PH_DATA) begin
         if (reg_addr_q >= `REG_LAST) begin
            reg_addr_q <= `REG_FIRST; // RULE_05
         end else begin
            reg_addr_q <= reg_addr_q + 8'h01; // RULE_05 RULE_11 RULE_15 RULE_18
         end
      end
   end

   // Data bytes go through the FIFO; a full FIFO drops the byte.
   assign push_valid    = byte_evt && phase_q == PH_DATA && !clr_busy_q; // RULE_10 RULE_14
   assign push_req.addr = reg_addr_q;
   assign push_req.data = byte_val;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         drop_q <= 1'b0;
      end else begin
         drop_q <= push_valid && !push_ready;
      end
   end

   // Acknowledge decision for the standard bus.
   always_comb begin
      case (phase_q)
         PH_DEV:  ack_now = dev_match;  // RULE_20 RULE_24 RULE_25
         PH_REG:  ack_now = 1'b1;       // RULE_25
         PH_DATA: ack_now = push_ready; // RULE_25
         default: ack_now = 1'b0;
      endcase
   end

   // The acknowledge is driven from the falling clock after the eighth bit
   // until the falling clock after the ninth.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_pend_q  <= 1'b0;
         ack_drive_q <= 1'b0;
      end else if (mode_q != MODE_STD || msg_start || msg_end) begin
         ack_pend_q  <= 1'b0;
         ack_drive_q <= 1'b0;
      end else begin
         if (byte_evt && ack_now) begin
            ack_pend_q <= 1'b1; // RULE_25
         end else if (sclk_fall && ack_pend_q) begin
            ack_pend_q <= 1'b0;
         end
         if (sclk_fall) begin
            ack_drive_q <= ack_pend_q; // RULE_25
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial_data_pin_out      <= 1'b0;
         serial_data_pin_oe_n_out <= 1'b1;
      end else begin
         serial_data_pin_out      <= 1'b0;
         serial_data_pin_oe_n_out <= !ack_drive_q; // RULE_25
      end
   end

   sync_fifo #(
      .WIDTH ($bits(wr_req_t)),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (push_valid),
      .in_ready_out  (push_ready),
      .in_data_in    (push_req),
      .out_valid_out (pop_valid),
      .out_ready_in  (pop_ready),
      .out_data_out  (pop_req)
   );

   // After reset every register is walked to zero before any write drains.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         clr_busy_q <= 1'b1;
         clr_idx_q  <= '0;
      end else if (clr_busy_q) begin
         clr_idx_q <= clr_idx_q + 1'b1;
         if (clr_idx_q == `REG_LAST) begin
            clr_busy_q <= 1'b0; // RULE_23
         end
      end
   end

   assign pop_ready = !clr_busy_q;

   // Writes beyond the last register are consumed and discarded.
   always_comb begin
      if (clr_busy_q) begin
         mem_we    = 1'b1; // RULE_23
         mem_waddr = clr_idx_q;
         mem_wdata = `REG_RESET_VAL;
      end else begin
         mem_we    = pop_valid && (pop_req.addr <= `REG_LAST);
         mem_waddr = pop_req.addr[`REG_AW-1:0];
         mem_wdata = pop_req.data;
      end
   end

   cfg_reg_mem #(
      .AW    (`REG_AW),
      .DEPTH (`REG_DEPTH)
   ) u_mem (
      .clk_in    (clk_in),
      .rstn_in   (rstn_in),
      .we_in     (mem_we),
      .waddr_in  (mem_waddr),
      .wdata_in  (mem_wdata),
      .raddr_in  (cfg_rd_addr_in),
      .rdata_out (cfg_rd_data_out)
   );

   // Status outputs.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         link_mode_out    <= MODE_3W;
         frame_active_out <= 1'b0;
         write_drop_out   <= 1'b0;
         clear_busy_out   <= 1'b1;
      end else begin
         link_mode_out    <= mode_q;
         frame_active_out <= (phase_q != PH_IDLE) && (phase_q != PH_SKIP);
         write_drop_out   <= drop_q;
         clear_busy_out   <= clr_busy_q;
      end
   end
endmodule : led_driver_serial_write_port

// *** dv/host_link_model.sv ***
// Host model that drives link frames and standard-bus writes into the port.
`timescale 1ns/1ps
module host_link_model (
   output logic      scl_out,
   output logic      sda_out,
   output logic      en_out,
   input  wire logic sda_in
);
   initial begin
      scl_out = 1'b0;
      sda_out = 1'b0;
      en_out  = 1'b0;
   end

   // The clock rises and falls only inside a message, 160 ns period.
   task automatic lbit(input logic b);
      #40 sda_out = b;
      #40 scl_out = 1'b1;
      #80 scl_out = 1'b0;
   endtask : lbit

   task automatic frame3(input logic [63:0] v, input int n);
      #1000 en_out = 1'b1;
      #80;
      for (int i = n - 1; i >= 0; i--) lbit(v[i]);
      #240 en_out = 1'b0;
      sda_out = ~sda_out;
   endtask : frame3

   task automatic bits2(input logic [63:0] v, input int n);
      #3;
      for (int i = n - 1; i >= 0; i--) lbit(v[i]);
      sda_out = ~sda_out;
   endtask : bits2

   task automatic i2c_start();
      #3 sda_out = 1'b1;
      #150 scl_out = 1'b1;
      #150 sda_out = 1'b0;
      #150 scl_out = 1'b0;
   endtask : i2c_start

   // Data changes only while the clock is low; 300 ns period.
   task automatic i2c_bit(input logic b, output logic got);
      #75 sda_out = b;
      #75 scl_out = 1'b1;
      #75 got = sda_in;
      #75 scl_out = 1'b0;
   endtask : i2c_bit

   task automatic i2c_byte(input logic [7:0] v, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) i2c_bit(v[i], got);
      i2c_bit(1'b1, got);
      ack = ~got;
   endtask : i2c_byte

   task automatic i2c_stop();
      #75 sda_out = 1'b0;
      #75 scl_out = 1'b1;
      #150 sda_out = 1'b1;
   endtask : i2c_stop
endmodule : host_link_model

// *** dv/led_port_monitor.sv ***
// Checker of the serial write port, bound to its top module.
`timescale 1ns/1ps
`include "led_port_cfg.svh"
module led_port_monitor (
   input wire logic                     clk_in,
   input wire logic                     rstn_in,
   input wire logic                     serial_clock_pin_in,
   input wire logic                     serial_data_pin_in,
   input wire logic                     frame_enable_pin_in,
   input wire logic [1:0]               bus_type_select_pin_in,
   input wire logic [5:0]               address_select_pins_in,
   input wire logic [`REG_AW-1:0]       cfg_rd_addr_in,
   input wire logic [7:0]               cfg_rd_data_out,
   input wire logic                     serial_data_pin_out,
   input wire logic                     serial_data_pin_oe_n_out,
   input wire led_port_pkg::link_mode_t link_mode_out,
   input wire logic                     frame_active_out,
   input wire logic                     write_drop_out,
   input wire logic                     clear_busy_out
);
   import led_port_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_clear_walk;
      $rose(rstn_in) |-> clear_busy_out [*8] ##24 !clear_busy_out;
   endproperty
   a_clear_walk: assert property (p_clear_walk)
      else $error("register clear walk has wrong length");
   property p_mode_3w;
      (bus_type_select_pin_in == `SEL_LOW) [*6] |-> link_mode_out == MODE_3W;
   endproperty
   a_mode_3w: assert property (p_mode_3w)
      else $error("low select did not give 3-wire mode");
   property p_mode_2w;
      (bus_type_select_pin_in == `SEL_HIGH) [*6] |-> link_mode_out == MODE_2W;
   endproperty
   a_mode_2w: assert property (p_mode_2w)
      else $error("high select did not give 2-wire mode");
   property p_mode_std;
      (bus_type_select_pin_in == `SEL_MID) [*6] |-> link_mode_out == MODE_STD;
   endproperty
   a_mode_std: assert property (p_mode_std)
      else $error("mid select did not give standard mode");
   property p_frame_en;
      (link_mode_out == MODE_3W && !frame_enable_pin_in) [*6] |-> !frame_active_out;
   endproperty
   a_frame_en: assert property (p_frame_en)
      else $error("3-wire message active without enable");
   property p_link_quiet;
      (link_mode_out != MODE_STD) [*2] |-> serial_data_pin_oe_n_out;
   endproperty
   a_link_quiet: assert property (p_link_quiet)
      else $error("data pin driven outside standard mode");
   property p_pin_low;
      !serial_data_pin_out;
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("data pin output is not low");
   property p_ack_clk_low;
      $fell(serial_data_pin_oe_n_out) |-> !serial_clock_pin_in;
   endproperty
   a_ack_clk_low: assert property (p_ack_clk_low)
      else $error("acknowledge started while clock high");
   property p_ack_release;
      !serial_data_pin_oe_n_out |-> ##[1:120] serial_data_pin_oe_n_out;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("acknowledge not released in time");

   c_ack: cover property ($fell(serial_data_pin_oe_n_out));
   c_f3w: cover property ($rose(frame_active_out) && link_mode_out == MODE_3W);
   c_f2w: cover property ($rose(frame_active_out) && link_mode_out == MODE_2W);
endmodule : led_port_monitor

bind led_driver_serial_write_port led_port_monitor u_mon (
   .clk_in, .rstn_in, .serial_clock_pin_in, .serial_data_pin_in, .frame_enable_pin_in,
   .bus_type_select_pin_in, .address_select_pins_in, .cfg_rd_addr_in, .cfg_rd_data_out,
   .serial_data_pin_out, .serial_data_pin_oe_n_out, .link_mode_out, .frame_active_out,
   .write_drop_out, .clear_busy_out
);

// *** dv/tb_led_driver_serial_write_port.sv ***
// Self-checking bench of the serial write port in all three link modes.
`timescale 1ns/1ps
`include "led_port_cfg.svh"
module tb_led_driver_serial_write_port;
   import led_port_pkg::*;
   logic        clk_in  = 1'b0;
   logic        rstn_in = 1'b0;
   logic [1:0]  sel_q   = `SEL_LOW;
   logic [5:0]  asel_q  = 6'h00;
   logic [4:0]  rd_addr_q = 5'h00;
   logic        rd_v1 = 1'b0;
   logic        rd_v2 = 1'b0;
   logic [7:0]  rd_data, dev, r, d0, d1, d2;
   logic        sd_out, oe_n, clr, ack;
   wire         scl, host_sda, en, sda_w;
   link_mode_t  mode;
   logic [7:0]  exp_mem [32];
   logic [7:0]  exp_q [$];
   logic [31:0] seed = 32'h0000_0016;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cyc = 0;

   // Open-drain wire: host and device acknowledge both pull it low.
   assign sda_w = host_sda & (oe_n | sd_out);

   led_driver_serial_write_port dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .serial_clock_pin_in(scl),
      .serial_data_pin_in(sda_w), .frame_enable_pin_in(en),
      .bus_type_select_pin_in(sel_q), .address_select_pins_in(asel_q),
      .cfg_rd_addr_in(rd_addr_q), .cfg_rd_data_out(rd_data),
      .serial_data_pin_out(sd_out), .serial_data_pin_oe_n_out(oe_n),
      .link_mode_out(mode), .frame_active_out(), .write_drop_out(),
      .clear_busy_out(clr)
   );
   host_link_model host (.scl_out(scl), .sda_out(host_sda), .en_out(en), .sda_in(sda_w));

   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      rd_v2 <= rd_v1;
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
   end
   always @(negedge clk_in) begin
      if (rd_v2) check(rd_data, exp_q.pop_front());
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0] | 8'h01;
   endfunction : rnd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   // Reads every register back; the watcher compares in arrival order.
   task automatic read_all();
      tick(10);
      for (int i = 0; i <= `REG_LAST; i++) begin
         @(posedge clk_in);
         rd_addr_q <= i[4:0];
         rd_v1 <= 1'b1;
         exp_q.push_back(exp_mem[i]);
      end
      @(posedge clk_in);
      rd_v1 <= 1'b0;
      tick(4);
   endtask : read_all

   task automatic set_mode(input logic [1:0] s, input link_mode_t m);
      @(posedge clk_in);
      sel_q <= s;
      tick(10);
      check({6'h00, mode}, {6'h00, m});
   endtask : set_mode

   task automatic std_ack(input logic [7:0] b, input logic [7:0] e);
      host.i2c_byte(b, ack);
      check({7'h00, ack}, e);
   endtask : std_ack

   initial begin
      foreach (exp_mem[i]) exp_mem[i] = 8'h00;
      r = rnd();
      asel_q = {1'b0, r[4:0]};
      dev = {2'b10, r[4:0], 1'b0};
      tick(5);
      rstn_in <= 1'b1;
      for (int i = 0; i < 200 && clr !== 1'b0; i++) @(posedge clk_in);
      check({7'h00, clr}, 8'h00);
      read_all();
      set_mode(`SEL_LOW, MODE_3W);
      d0 = rnd();
      d1 = rnd();
      d2 = rnd();
      host.frame3({dev, 8'h1C, d0, d1, d2, 4'hA}, 44);
      exp_mem[5'h1C] = d0;
      exp_mem[5'h1D] = d1;
      exp_mem[5'h00] = d2;
      host.frame3({dev, 8'h05, d0[7:1]}, 23);
      host.frame3({dev ^ 8'h04, 8'h06, d0}, 24);
      @(posedge clk_in);
      asel_q <= 6'h38;
      tick(10);
      host.frame3({8'hF0, 8'h07, d0}, 24);
      @(posedge clk_in);
      asel_q <= {1'b0, r[4:0]};
      read_all();
      set_mode(`SEL_HIGH, MODE_2W);
      host.bits2({10'h3FE, dev, 1'b0, 8'h03, 1'b0, d0, 1'b0}, 37);
      host.bits2({10'h3FE, dev, 1'b0, 8'h07, 1'b0, d1, 1'b0, d2, 1'b0}, 46);
      host.bits2({10'h3FE, dev, 1'b0, 8'h04, 1'b0, d0, 1'b1, 8'h00, 1'b0}, 46);
      host.bits2({10'h3FE, dev, 1'b0, 5'h00, 10'h3FE, dev, 1'b0, 8'h06, 1'b0, d2, 1'b0},
                 61);
      host.bits2({10'h3FE, dev, 1'b0, 8'h09, 1'b0, d0}, 36);
      exp_mem[5'h03] = d0;
      exp_mem[5'h07] = d1;
      exp_mem[5'h08] = d2;
      exp_mem[5'h06] = d2;
      read_all();
      set_mode(`SEL_MID, MODE_STD);
      host.i2c_start();
      std_ack(dev, 8'h01);
      std_ack(8'h0A, 8'h01);
      std_ack(d1, 8'h01);
      std_ack(d0, 8'h01);
      host.i2c_stop();
      exp_mem[5'h0A] = d1;
      exp_mem[5'h0B] = d0;
      host.i2c_start();
      std_ack(dev | 8'h01, 8'h00);
      host.i2c_stop();
      host.i2c_start();
      std_ack(dev ^ 8'h04, 8'h00);
      host.i2c_stop();
      read_all();
      test_done();
   end
endmodule : tb_led_driver_serial_write_port
